// >>> rtl/sbrg_pkg.sv
/*
  package of the serial bit rate generator: register offsets, field layout,
  reset values and divider constants.
  assumes a 32-bit apb slave on pclk and a single clock domain.
*/
package sbrg_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] SBRG_DIV_SEL_OFS    = 12'h000;
  localparam logic [11:0] SBRG_STATUS_OFS     = 12'h004;
  localparam logic [7:0]  SBRG_DIV_SEL_RST    = 8'h00;

  // field positions inside bit_rate_divider_select
  localparam int          SBRG_RATE_LSB       = 0;
  localparam int          SBRG_PRE_LSB        = 4;

  // ************************************************************
  // divider constants
  // ************************************************************
  localparam int          SBRG_FIXED_DIV      = 64;
  localparam logic [5:0]  SBRG_FIXED_LAST     = 6'h3f;
  localparam logic [3:0]  SBRG_PRE_LAST_0     = 4'h0;
  localparam logic [3:0]  SBRG_PRE_LAST_1     = 4'h2;
  localparam logic [3:0]  SBRG_PRE_LAST_2     = 4'h3;
  localparam logic [3:0]  SBRG_PRE_LAST_3     = 4'hc;
  localparam logic [6:0]  SBRG_RATE_CNT_RST   = 7'h00;
  localparam logic [3:0]  SBRG_PRE_CNT_RST    = 4'h0;
  localparam logic [5:0]  SBRG_FIXED_CNT_RST  = 6'h00;

  typedef struct packed {
    logic [1:0] prescale_code;
    logic [2:0] rate_code;
  } sbrg_sel_s;

endpackage

// >>> rtl/sbrg_stage.sv
/*
  one counting stage of the divider cascade: counts enabled pulses up to a
  last value, then emits a one-cycle carry and wraps.
  assumes in_en is a one-cycle pulse on pclk.
*/
`timescale 1ns/10ps
module sbrg_stage #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         restart,
  input  wire logic         in_en,
  input  wire logic [W-1:0] last,
  output logic              carry
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         at_last;

  assign at_last = (cnt_ff >= last);
  assign carry   = in_en & at_last;
  assign nxt_cnt = restart ? '0 : (in_en ? (at_last ? '0 : cnt_ff + 1'b1) : cnt_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// >>> rtl/sbrg_top.sv
/*
  serial bit rate generator: apb register bit_rate_divider_select and a
  cascade of fixed, prescale and power-of-two dividers making baud_tick.
  assumes pclk is the reference clock and one apb master.
*/
`timescale 1ns/10ps
module sbrg_top
  import sbrg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             baud_tick,
  output logic [4:0]       rate_sel
);

  // ************************************************************
  // apb decode
  // ************************************************************
  logic        setup;
  logic        acc;
  logic        rd_setup;
  logic        hit_sel;
  logic        hit_stat;
  logic        hit_any;
  logic        wr_sel;
  logic [1:0]  wr_pre_code;
  logic [2:0]  wr_rate_code;

  assign setup        = psel & ~penable;
  assign acc          = psel & penable;
  assign rd_setup     = setup & ~pwrite;
  assign hit_sel      = (paddr == SBRG_DIV_SEL_OFS);
  assign hit_stat     = (paddr == SBRG_STATUS_OFS);
  assign hit_any      = hit_sel | hit_stat;
  // writes to the status word and to unmapped words are dropped
  assign wr_sel       = acc & pwrite & hit_sel;
  assign wr_pre_code  = pwdata[SBRG_PRE_LSB +: 2];
  assign wr_rate_code = pwdata[SBRG_RATE_LSB +: 3];

  // ************************************************************
  // divider select register
  // ************************************************************
  sbrg_sel_s   sel_ff;
  sbrg_sel_s   nxt_sel;
  logic        restart_ff;

  assign nxt_sel = wr_sel ? sbrg_sel_s'({wr_pre_code, wr_rate_code}) : sel_ff;

  // every write to bit_rate_divider_select restarts the cascade, even with unchanged codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff.prescale_code <= SBRG_DIV_SEL_RST[SBRG_PRE_LSB +: 2];
      sel_ff.rate_code     <= SBRG_DIV_SEL_RST[SBRG_RATE_LSB +: 3];
      restart_ff           <= 1'b0;
    end else begin
      sel_ff               <= nxt_sel;
      restart_ff           <= wr_sel;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [31:0] rd_div_word;
  logic [31:0] rd_stat_word;
  logic [7:0]  sel_byte;
  logic        tick_ff;

  // fields read back where they are written; other bits read zero
  assign sel_byte     = {2'b00, sel_ff.prescale_code, 1'b0, sel_ff.rate_code};
  assign rd_div_word  = {24'h000000, sel_byte};
  assign rd_stat_word = {31'h00000000, tick_ff};
  // taken in the setup cycle, stands until the next read setup
  assign nxt_prdata   = ~rd_setup ? prdata_ff    :
                        hit_sel   ? rd_div_word  :
                        hit_stat  ? rd_stat_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ************************************************************
  // error response
  // ************************************************************
  logic        pslverr_ff;
  logic        nxt_pslverr;

  // raised in the setup cycle so it stands through the access phase
  assign nxt_pslverr = setup & ~hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ************************************************************
  // bus outputs
  // ************************************************************
  // zero wait states: every access phase completes at once
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pready  = 1'b1;

  // ************************************************************
  // prescale decode
  // ************************************************************
  logic       pre_is_1;
  logic       pre_is_3;
  logic       pre_is_4;
  logic       pre_is_13;
  logic [3:0] pre_last;

  assign pre_is_1  = (sel_ff.prescale_code == 2'b00);
  assign pre_is_3  = (sel_ff.prescale_code == 2'b01);
  assign pre_is_4  = (sel_ff.prescale_code == 2'b10);
  assign pre_is_13 = (sel_ff.prescale_code == 2'b11);
  // the prescale stage wraps at its factor minus one
  assign pre_last  = ({4{pre_is_1}}  & SBRG_PRE_LAST_0) |
                     ({4{pre_is_3}}  & SBRG_PRE_LAST_1) |
                     ({4{pre_is_4}}  & SBRG_PRE_LAST_2) |
                     ({4{pre_is_13}} & SBRG_PRE_LAST_3);

  // ************************************************************
  // rate decode
  // ************************************************************
  logic [7:0] rate_onehot;
  logic [6:0] rate_last;

  // the power-of-two stage wraps after two to the power n enables
  assign rate_onehot = 8'h01 << sel_ff.rate_code;
  assign rate_last   = 7'(rate_onehot - 8'h01);

  // ************************************************************
  // fixed stage: divide by 64
  // ************************************************************
  logic       fixed_carry;

  sbrg_stage #(.W(6)) u_fixed (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (restart_ff),
    .in_en   (1'b1),
    .last    (SBRG_FIXED_LAST),
    .carry   (fixed_carry)
  );

  // ************************************************************
  // prescale stage
  // ************************************************************
  logic       pre_carry;

  sbrg_stage #(.W(4)) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (restart_ff),
    .in_en   (fixed_carry),
    .last    (pre_last),
    .carry   (pre_carry)
  );

  // ************************************************************
  // power-of-two stage
  // ************************************************************
  logic       rate_carry;

  sbrg_stage #(.W(7)) u_rate (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (restart_ff),
    .in_en   (pre_carry),
    .last    (rate_last),
    .carry   (rate_carry)
  );

  // ************************************************************
  // tick output
  // ************************************************************
  logic       nxt_tick;

  assign nxt_tick = rate_carry;

  // one registered tick drives both baud_tick and the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign baud_tick = tick_ff;

  // ************************************************************
  // select copy output
  // ************************************************************
  logic [4:0] rate_sel_ff;
  logic [4:0] nxt_rate_sel;

  assign nxt_rate_sel = {sel_ff.prescale_code, sel_ff.rate_code};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_sel_ff <= 5'h00;
    end else begin
      rate_sel_ff <= nxt_rate_sel;
    end
  end

  assign rate_sel = rate_sel_ff;

endmodule

// >>> tb/sbrg_sva.sv
/*
  checker of the bit rate generator ports: apb answers, field copy, tick timing.
  assumes it is bound to every sbrg_top instance.
*/
`timescale 1ns/10ps
module sbrg_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        baud_tick,
  input wire logic [4:0]  rate_sel
);
  // ************************************************************
  // helper logic
  // ************************************************************
  wire        acc = psel && penable;
  wire        wr0 = acc && pwrite && paddr == 12'h000;
  wire [1:0]  pc  = rate_sel[4:3];
  wire [3:0]  pd  = pc == 2'h0 ? 4'h1 : pc == 2'h1 ? 4'h3 : pc == 2'h2 ? 4'h4 : 4'hd;
  wire [16:0] per = (17'h40 * pd) << rate_sel[2:0];
  logic [16:0] cnt_ff;
  logic [1:0]  cl_ff;
  logic [4:0]  wsel_ff;
  // codes of the last accepted write to the divider register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wsel_ff <= 5'h00;
    else if (wr0) wsel_ff <= {pwdata[5:4], pwdata[2:0]};
  end
  // cycles since last tick; cl_ff counts ticks since the last write, holding at 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_ff <= 17'h0;
    else cnt_ff <= baud_tick ? 17'h1 : cnt_ff + 17'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cl_ff <= 2'h0;
    else cl_ff <= wr0 ? 2'h0 : (baud_tick && !cl_ff[1]) ? cl_ff + 2'h1 : cl_ff;
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_tick_period: assert property (baud_tick && cl_ff[1] |-> cnt_ff == per)
    else $error("tick period wrong");
  chk_tick_pulse: assert property (baud_tick |=> !baud_tick [*8])
    else $error("tick not a single pulse");
  chk_sel_reset: assert property ($rose(presetn) |-> rate_sel == 5'h00)
    else $error("codes not cleared");
  chk_sel_write: assert property (wr0 |-> ##2 rate_sel == wsel_ff)
    else $error("codes not written");
  chk_sel_hold: assert property (!wr0 [*3] |=> $stable(rate_sel))
    else $error("codes changed without write");
  chk_read_div: assert property (acc && !pwrite && paddr == 12'h000 |->
    prdata == {26'h0, rate_sel[4:3], 1'b0, rate_sel[2:0]})
    else $error("divider read wrong");
  chk_unmapped_err: assert property (acc && !pwrite && paddr != 12'h000 && paddr != 12'h004
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_ready_high: assert property (acc |-> pready)
    else $error("access not answered");
endmodule
bind sbrg_top sbrg_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .baud_tick(baud_tick), .rate_sel(rate_sel));

// >>> tb/testbench.sv
/*
  self-checking bench of the bit rate generator over apb.
  assumes sbrg_pkg, sbrg_top and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module testbench
  import sbrg_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, baud_tick, er;
  logic [4:0]  rate_sel;
  logic [16:0] n;
  logic [7:0]  sel [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h07, 8'h32};
  int          err_count = 0, n_tests = 0, cyc = 0;
  always #20 pclk = ~pclk;
  sbrg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick(baud_tick), .rate_sel(rate_sel));
  // ************************************************************
  // tasks
  // ************************************************************
  task results;
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      results;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // skip two ticks, then count cycles to the next one
  task per(output logic [16:0] c);
    c = 17'h0;
    repeat (2) do @(posedge pclk); while (baud_tick !== 1'b1);
    do begin
      @(posedge pclk);
      c++;
    end while (baud_tick !== 1'b1);
  endtask
  function automatic logic [16:0] exp_per(input logic [7:0] v);
    logic [3:0] pd;
    pd = v[5:4] == 2'h0 ? 4'h1 : v[5:4] == 2'h1 ? 4'h3 : v[5:4] == 2'h2 ? 4'h4 : 4'hd;
    return (17'h40 * pd) << v[2:0];
  endfunction
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("div_sel", 32'h0, rd);
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0);
    chk("div_sel", 32'h37, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    foreach (sel[i]) begin
      apb(1'b1, 12'h000, {24'h0, sel[i]});
      apb(1'b0, 12'h000, 32'h0);
      chk("div_sel", {24'h0, sel[i]}, rd);
      chk("rate_sel", {27'h0, sel[i][5:4], sel[i][2:0]}, {27'h0, rate_sel});
      per(n);
      chk("tick_period", {15'h0, exp_per(sel[i])}, {15'h0, n});
    end
    // period 64: a status read set up 64 cycles after a tick sees the next one
    apb(1'b1, 12'h000, 32'h0);
    per(n);
    repeat (62) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h1, rd);
    chk("pslverr", 32'h0, {31'h0, er});
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h0, rd);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("div_sel", 32'h0, rd);
    results;
  end
endmodule
